// ===== hw/cmpl_regs.svh
// Purpose: Register offsets, field positions and reset values of the comparator output logic
// Assumes: Byte-wide registers on a plain strobe port, one register per address
// Notes:   Definitions only
`ifndef CMPL_REGS_SVH
`define CMPL_REGS_SVH

`define CMPL_ADDR_W          4
`define CMPL_OFF_CTRL0       4'h0
`define CMPL_OFF_CTRL1       4'h1
`define CMPL_OFF_MIRROR      4'h2
`define CMPL_OFF_IRQSTAT     4'h3
`define CMPL_OFF_IRQMASK     4'h4

`define CMPL_BIT_ON          7
`define CMPL_BIT_OUT         6
`define CMPL_BIT_POL         4
`define CMPL_BIT_HYS         1
`define CMPL_BIT_SYNC        0
`define CMPL_BIT_RISE        1
`define CMPL_BIT_FALL        0
`define CMPL_BIT_MIRROR      0
`define CMPL_BIT_FLAG        0

`define CMPL_RST_CTRL0       8'h00
`define CMPL_RST_CTRL1       8'h00
`define CMPL_RST_MASK        8'h00

`endif

// ===== hw/cmpl_pkg.sv
// Purpose: Shared types of the comparator output logic
// Assumes: Nothing beyond the register header
// Notes:   Types only
`default_nettype none
package cmpl_pkg;

	typedef struct packed {
		logic on;
		logic pol;
		logic hys;
		logic sync;
	} cmpl_ctrl_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} cmpl_edge_t;

	typedef enum logic [2:0] {
		CMPL_SYNC_IDLE = 3'b001,
		CMPL_SYNC_HIGH = 3'b010,
		CMPL_SYNC_LOW  = 3'b100
	} cmpl_tclk_t;

endpackage
`default_nettype wire

// ===== hw/cmpl_edge_det.sv
// Purpose: Rising and falling edge detector against the previous cycle
// Assumes: Input already synchronous to clk
// Notes:   One pulse per transition
`timescale 1ns/10ps
`default_nettype none
module cmpl_edge_det
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 level,
	output cmpl_pkg::cmpl_edge_t      edges
);
	logic prevQ;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			prevQ <= 1'b0;
		else
			prevQ <= level;
	end

	assign edges.rise = level & ~prevQ;
	assign edges.fall = ~level & prevQ;

	chk_rise_once: assert property (@(posedge clk) disable iff (!rst_n) edges.rise |=> !edges.rise)
		else $error("rise detected twice in a row");
endmodule // cmpl_edge_det
`default_nettype wire

// ===== hw/cmpl_tsync.sv
// Purpose: Latch the comparator output on the falling edge of the gating timer clock
// Assumes: Timer clock is a sampled level on clk, already after the prescaler
// Notes:   Output moves only on timer falling edges
`timescale 1ns/10ps
`default_nettype none
module cmpl_tsync
(
	input  wire logic   clk,
	input  wire logic   rst_n,
	input  wire logic   timerClk,
	input  wire logic   din,
	output logic        dout
);
	cmpl_pkg::cmpl_tclk_t stateQ;
	logic                 fallEdge;

	// Falling edge seen as a high-to-low step of the sampled clock
	assign fallEdge = (stateQ == cmpl_pkg::CMPL_SYNC_HIGH) && !timerClk;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			stateQ <= cmpl_pkg::CMPL_SYNC_IDLE;
		else
			case (stateQ)
				cmpl_pkg::CMPL_SYNC_IDLE: stateQ <= timerClk ? cmpl_pkg::CMPL_SYNC_HIGH : cmpl_pkg::CMPL_SYNC_LOW;
				cmpl_pkg::CMPL_SYNC_HIGH: stateQ <= timerClk ? cmpl_pkg::CMPL_SYNC_HIGH : cmpl_pkg::CMPL_SYNC_LOW;
				cmpl_pkg::CMPL_SYNC_LOW:  stateQ <= timerClk ? cmpl_pkg::CMPL_SYNC_HIGH : cmpl_pkg::CMPL_SYNC_LOW;
				default:                  stateQ <= cmpl_pkg::CMPL_SYNC_IDLE;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			dout <= 1'b0;
		else if (fallEdge)
			dout <= din;
	end

	chk_sync_fall_only: assert property (@(posedge clk) disable iff (!rst_n)
		!$stable(dout) |-> $past(stateQ) == cmpl_pkg::CMPL_SYNC_HIGH && !$past(timerClk))
		else $error("synchronized output moved off a timer falling edge");
endmodule // cmpl_tsync
`default_nettype wire

// ===== hw/cmpl_top.sv
// Purpose: Digital logic around one analog comparator: enable, polarity, sync, edge interrupt
// Assumes: rawCompare from the analog core, timerClk after the timer prescaler, both synchronous
// Notes:   Interrupt flag set wins over a software clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
`include "cmpl_regs.svh"
// How it works
// - Raw result high when positive input higher
// - comparator_on enables core, off saves power
// - Output readable in control and mirror registers
// - Internal output latched every instruction cycle
// - invert_output complements the raw result
// - hysteresis_on adds separation voltage
// - Output offered as timer gate source
// - Sync latches output on timer falling edge
// - Sync output changes only on falling edges
// - Own rising and falling edge detectors
// - Enabled edge sets compare_irq_flag
// - Edge during clear leaves flag set
// - Polarity or enable toggles may raise flag
module cmpl_top
#(
	parameter int DATA_W = 8
)
(
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic [`CMPL_ADDR_W-1:0]    regAddr,
	input  wire logic [DATA_W-1:0]          regWdata,
	input  wire logic                       regWrite,
	input  wire logic                       regRead,
	output logic      [DATA_W-1:0]          regRdata,
	input  wire logic                       rawCompare,
	input  wire logic                       timerClk,
	output logic                            coreEnable,
	output logic                            hysteresisOn,
	output logic                            compareOut,
	output logic                            gateSource,
	output logic                            pinOut,
	output logic                            irq
);
	// Register fields sit at fixed bit positions up to bit 7
	if (DATA_W < 8)
	begin : g_width_check
		$error("DATA_W must be at least 8");
	end

	localparam logic [7:0] RST_CTRL0 = `CMPL_RST_CTRL0;
	localparam logic [7:0] RST_CTRL1 = `CMPL_RST_CTRL1;
	localparam logic [7:0] RST_MASK  = `CMPL_RST_MASK;

	cmpl_pkg::cmpl_ctrl_t ctrlQ;
	cmpl_pkg::cmpl_edge_t edgeEnQ;
	cmpl_pkg::cmpl_edge_t edges;
	logic                 flagQ;
	logic                 maskQ;
	logic                 outQ;
	logic                 syncOut;
	logic                 polOut;
	logic                 wrCtrl0;
	logic                 wrCtrl1;
	logic                 wrStat;
	logic                 wrMask;
	logic                 flagSet;

	assign wrCtrl0 = regWrite && regAddr == `CMPL_OFF_CTRL0;
	assign wrCtrl1 = regWrite && regAddr == `CMPL_OFF_CTRL1;
	assign wrStat  = regWrite && regAddr == `CMPL_OFF_IRQSTAT;
	assign wrMask  = regWrite && regAddr == `CMPL_OFF_IRQMASK;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrlQ.on   <= RST_CTRL0[`CMPL_BIT_ON];
			ctrlQ.pol  <= RST_CTRL0[`CMPL_BIT_POL];
			ctrlQ.hys  <= RST_CTRL0[`CMPL_BIT_HYS];
			ctrlQ.sync <= RST_CTRL0[`CMPL_BIT_SYNC];
		end
		else if (wrCtrl0)
		begin
			ctrlQ.on   <= regWdata[`CMPL_BIT_ON];
			ctrlQ.pol  <= regWdata[`CMPL_BIT_POL];
			ctrlQ.hys  <= regWdata[`CMPL_BIT_HYS];
			ctrlQ.sync <= regWdata[`CMPL_BIT_SYNC];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			edgeEnQ.rise <= RST_CTRL1[`CMPL_BIT_RISE];
			edgeEnQ.fall <= RST_CTRL1[`CMPL_BIT_FALL];
		end
		else if (wrCtrl1)
		begin
			edgeEnQ.rise <= regWdata[`CMPL_BIT_RISE];
			edgeEnQ.fall <= regWdata[`CMPL_BIT_FALL];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			maskQ <= RST_MASK[`CMPL_BIT_FLAG];
		else if (wrMask)
			maskQ <= regWdata[`CMPL_BIT_FLAG];
	end

	// Core held off when disabled; the raw result is forced low so the output is defined
	assign coreEnable   = ctrlQ.on;
	assign hysteresisOn = ctrlQ.on & ctrlQ.hys;
	// Polarity still applies when disabled, so toggling it or on can make an edge
	assign polOut = (ctrlQ.on & rawCompare) ^ ctrlQ.pol;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			outQ <= 1'b0;
		else
			outQ <= polOut;
	end

	cmpl_tsync u_tsync
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.timerClk (timerClk),
		.din      (outQ),
		.dout     (syncOut)
	);

	cmpl_edge_det u_edge
	(
		.clk   (clk),
		.rst_n (rst_n),
		.level (outQ),
		.edges (edges)
	);

	assign compareOut = outQ;
	// External path skips the instruction-cycle latch unless synchronised to the timer
	assign gateSource = ctrlQ.sync ? syncOut : polOut;
	assign pinOut     = gateSource;

	assign flagSet = (edges.rise & edgeEnQ.rise) | (edges.fall & edgeEnQ.fall);

	// Set beats a write-one clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			flagQ <= 1'b0;
		else if (flagSet)
			flagQ <= 1'b1;
		else if (wrStat && regWdata[`CMPL_BIT_FLAG])
			flagQ <= 1'b0;
	end

	assign irq = flagQ & maskQ;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			regRdata <= '0;
		else if (regRead)
		begin
			regRdata <= '0;
			case (regAddr)
				`CMPL_OFF_CTRL0:
				begin
					regRdata[`CMPL_BIT_ON]   <= ctrlQ.on;
					regRdata[`CMPL_BIT_OUT]  <= outQ;
					regRdata[`CMPL_BIT_POL]  <= ctrlQ.pol;
					regRdata[`CMPL_BIT_HYS]  <= ctrlQ.hys;
					regRdata[`CMPL_BIT_SYNC] <= ctrlQ.sync;
				end
				`CMPL_OFF_CTRL1:
				begin
					regRdata[`CMPL_BIT_RISE] <= edgeEnQ.rise;
					regRdata[`CMPL_BIT_FALL] <= edgeEnQ.fall;
				end
				`CMPL_OFF_MIRROR:  regRdata[`CMPL_BIT_MIRROR] <= outQ;
				`CMPL_OFF_IRQSTAT: regRdata[`CMPL_BIT_FLAG]   <= flagQ;
				`CMPL_OFF_IRQMASK: regRdata[`CMPL_BIT_FLAG]   <= maskQ;
				default:           regRdata <= '0;
			endcase
		end
		else
			regRdata <= '0;
	end

	chk_raw_polarity: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> outQ == (($past(ctrlQ.on) & $past(rawCompare)) ^ $past(ctrlQ.pol)))
		else $error("output does not follow raw result and polarity");

	chk_off_output: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrlQ.on ##1 !ctrlQ.on |-> outQ == ctrlQ.pol || !$stable(ctrlQ.pol))
		else $error("disabled comparator output not at polarity");

	chk_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		flagSet |=> flagQ)
		else $error("enabled edge did not set flag");

	chk_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		flagSet && wrStat && regWdata[`CMPL_BIT_FLAG] |=> flagQ)
		else $error("clear beat a same-cycle edge");

	chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		flagQ && !wrStat |=> flagQ)
		else $error("flag dropped without software clear");

	chk_no_spurious: assert property (@(posedge clk) disable iff (!rst_n)
		!flagQ && !flagSet |=> !flagQ)
		else $error("flag set without enabled edge");

	chk_mirror_read: assert property (@(posedge clk) disable iff (!rst_n)
		regRead && regAddr == `CMPL_OFF_MIRROR |=> regRdata[`CMPL_BIT_MIRROR] == $past(outQ))
		else $error("mirror read wrong");

	chk_gate_select: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrlQ.sync |-> gateSource == polOut)
		else $error("gate source not the output when unsynced");

	chk_hys_follow: assert property (@(posedge clk) disable iff (!rst_n)
		hysteresisOn == (ctrlQ.on && ctrlQ.hys))
		else $error("hysteresis control wrong");

	// Enable must have been off a cycle earlier too, else the old output may already match
	chk_pol_edge: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(ctrlQ.pol) && !ctrlQ.on && !$past(ctrlQ.on) && edgeEnQ == 2'b11 && !wrCtrl1 |=> ##1 flagQ)
		else $error("polarity toggle did not raise flag");

	chk_write_on: assert property (@(posedge clk) disable iff (!rst_n)
		wrCtrl0 |=> coreEnable == $past(regWdata[`CMPL_BIT_ON]))
		else $error("core enable does not follow the written bit");

	chk_hys_write: assert property (@(posedge clk) disable iff (!rst_n)
		wrCtrl0 |=> hysteresisOn == ($past(regWdata[`CMPL_BIT_ON]) && $past(regWdata[`CMPL_BIT_HYS])))
		else $error("hysteresis does not follow the written bits");

	chk_ctrl0_read: assert property (@(posedge clk) disable iff (!rst_n)
		regRead && regAddr == `CMPL_OFF_CTRL0 |=> regRdata[`CMPL_BIT_OUT] == $past(outQ))
		else $error("control read shows wrong output bit");

	chk_read_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!regRead |=> regRdata == '0)
		else $error("read data not zero outside a read");

	chk_edge_rise: assert property (@(posedge clk) disable iff (!rst_n)
		outQ && !$past(outQ) |-> edges.rise)
		else $error("rising output step not detected");

	chk_edge_fall: assert property (@(posedge clk) disable iff (!rst_n)
		!outQ && $past(outQ) |-> edges.fall)
		else $error("falling output step not detected");

	chk_edge_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		outQ == $past(outQ) |-> !edges.rise && !edges.fall)
		else $error("edge detected on a steady output");

	chk_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
		wrStat && regWdata[`CMPL_BIT_FLAG] && !flagSet |=> !flagQ)
		else $error("write one did not clear the flag");

	// The timer counts on rising edges, so the gate must only move after a fall
	chk_sync_steady: assert property (@(posedge clk) disable iff (!rst_n)
		ctrlQ.sync && $past(ctrlQ.sync) && $changed(gateSource) |-> !$past(timerClk) && $past(timerClk, 2))
		else $error("synchronized gate source moved off a timer falling edge");


	cov_rise_irq: cover property (@(posedge clk) disable iff (!rst_n) edges.rise && edgeEnQ.rise);
	cov_fall_irq: cover property (@(posedge clk) disable iff (!rst_n) edges.fall && edgeEnQ.fall);
	cov_set_clear: cover property (@(posedge clk) disable iff (!rst_n) flagSet && wrStat);
	cov_sync_gate: cover property (@(posedge clk) disable iff (!rst_n) ctrlQ.sync && $changed(gateSource));
	cov_pol_off: cover property (@(posedge clk) disable iff (!rst_n) !ctrlQ.on && $changed(ctrlQ.pol));
endmodule // cmpl_top
`default_nettype wire

// ===== sim/cmpl_partner_model.sv
// Purpose: Analog comparator core and gating timer clock seen from the logic
// Assumes: Levels given as unsigned codes; equal codes are never applied
// Notes:   Timer clock rests high while stopped, so its first move is a fall
`timescale 1ns/10ps
`default_nettype none
module cmpl_partner_model
(
	input  wire logic       clk,
	input  wire logic       coreEnable,
	input  wire logic [7:0] vPos,
	input  wire logic [7:0] vNeg,
	input  wire logic       runTmr,
	output logic            rawCompare,
	output var logic        timerClk
);
	logic [1:0] divQ;
	// A core that is off draws no current and its result rests low
	assign rawCompare = coreEnable && (vPos > vNeg);
	always_ff @(posedge clk)
	begin
		if (!runTmr)
		begin
			divQ     <= 2'h0;
			timerClk <= 1'h1;
		end
		else
		begin
			divQ <= divQ + 2'h1;
			if (divQ == 2'h1)
				timerClk <= ~timerClk;
		end
	end
endmodule // cmpl_partner_model
`default_nettype wire

// ===== sim/cmpl_top_tb_top.sv
// Purpose: Self-checking bench for the comparator output logic
// Assumes: Partner model supplies the raw result and the timer clock
// Notes:   Fixed waits follow the register and output latencies of the block
`timescale 1ns/10ps
`default_nettype none
`include "cmpl_regs.svh"
module cmpl_top_tb_top;
	localparam logic [3:0] CT0 = `CMPL_OFF_CTRL0;
	localparam logic [3:0] CT1 = `CMPL_OFF_CTRL1;
	localparam logic [3:0] MIR = `CMPL_OFF_MIRROR;
	localparam logic [3:0] STA = `CMPL_OFF_IRQSTAT;
	localparam logic [3:0] MSK = `CMPL_OFF_IRQMASK;
	logic       clk = 1'h0;
	logic       rst_n = 1'h0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00;
	logic       regWrite = 1'h0;
	logic       regRead = 1'h0;
	logic       runTmr = 1'h0;
	logic [7:0] vPos = 8'h40;
	logic [7:0] vNeg = 8'h80;
	logic [7:0] regRdata;
	logic       rawCompare, timerClk, coreEnable, hysteresisOn;
	logic       compareOut, gateSource, pinOut, irq;
	int         errors = 0;
	int         checksDone = 0;
	always #12.5 clk = ~clk;
	cmpl_top uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .rawCompare(rawCompare), .timerClk(timerClk),
		.coreEnable(coreEnable), .hysteresisOn(hysteresisOn), .compareOut(compareOut),
		.gateSource(gateSource), .pinOut(pinOut), .irq(irq));
	cmpl_partner_model far (.clk(clk), .coreEnable(coreEnable), .vPos(vPos), .vNeg(vNeg),
		.runTmr(runTmr), .rawCompare(rawCompare), .timerClk(timerClk));
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checksDone++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'h1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'h0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'h0;
		#1;
		cmp(what, exp, regRdata);
	endtask
	task automatic setV(input logic hi);
		@(posedge clk);
		vPos <= hi ? 8'hC0 : 8'h40;
	endtask
	task automatic t_reset;
		for (int a = 0; a < 8; a++)
			rdc(4'(a), 8'h00, "reset value");
		wr(4'h7, 8'hFF);
		rdc(4'h7, 8'h00, "unmapped");
		$display("reset test done");
	endtask
	task automatic t_polarity;
		logic e;
		for (int i = 0; i < 4; i++)
		begin
			wr(CT0, {1'h1, 2'h0, i[1], 3'h1, 1'h0});
			setV(i[0]);
			cyc(3);
			e = i[0] ^ i[1];
			cmp("compareOut", 8'(e), 8'(compareOut));
			rdc(CT0, {1'h1, e, 1'h0, i[1], 3'h1, 1'h0}, "ctrl0");
			rdc(MIR, 8'(e), "mirror");
			cmp("coreEnable", 8'h01, 8'(coreEnable));
			cmp("hysteresisOn", 8'h01, 8'(hysteresisOn));
		end
		wr(MIR, 8'hFF);
		rdc(MIR, 8'h00, "mirror");
		wr(CT0, 8'h80);
		cyc(2);
		cmp("hysteresisOn", 8'h00, 8'(hysteresisOn));
		$display("polarity test done");
	endtask
	task automatic t_edges;
		wr(MSK, 8'h01);
		wr(CT1, 8'h02);
		setV(1'h0);
		cyc(4);
		wr(STA, 8'h01);
		cyc(2);
		cmp("irq", 8'h00, 8'(irq));
		setV(1'h1);
		cyc(4);
		cmp("irq", 8'h01, 8'(irq));
		cyc(20);
		rdc(STA, 8'h01, "status");
		wr(STA, 8'h01);
		cyc(2);
		cmp("irq", 8'h00, 8'(irq));
		setV(1'h0);
		cyc(4);
		cmp("irq", 8'h00, 8'(irq));
		wr(CT1, 8'h01);
		setV(1'h1);
		cyc(4);
		cmp("irq", 8'h00, 8'(irq));
		setV(1'h0);
		cyc(4);
		cmp("irq", 8'h01, 8'(irq));
		wr(MSK, 8'h00);
		cyc(2);
		cmp("irq", 8'h00, 8'(irq));
		wr(MSK, 8'h01);
		$display("edge test done");
	endtask
	task automatic t_collide;
		// Flag cleared first, so only the set-wins rule can leave it high
		wr(CT1, 8'h03);
		wr(STA, 8'h01);
		@(posedge clk);
		vPos <= 8'hC0;
		@(posedge clk);
		regWrite <= 1'h1;
		regAddr  <= STA;
		regWdata <= 8'h01;
		@(posedge clk);
		regWrite <= 1'h0;
		cyc(2);
		rdc(STA, 8'h01, "status");
		wr(STA, 8'h01);
		cyc(2);
		rdc(STA, 8'h00, "status");
		$display("collision test done");
	endtask
	task automatic t_disabled;
		wr(CT0, 8'h00);
		wr(CT1, 8'h02);
		cyc(3);
		wr(STA, 8'h01);
		wr(CT0, 8'h10);
		cyc(3);
		cmp("compareOut", 8'h01, 8'(compareOut));
		cmp("irq", 8'h01, 8'(irq));
		cmp("coreEnable", 8'h00, 8'(coreEnable));
		wr(CT1, 8'h03);
		wr(STA, 8'h01);
		wr(CT0, 8'h00);
		cyc(3);
		cmp("irq", 8'h01, 8'(irq));
		wr(STA, 8'h01);
		wr(CT0, 8'h80);
		cyc(3);
		cmp("irq", 8'h01, 8'(irq));
		cmp("coreEnable", 8'h01, 8'(coreEnable));
		$display("disabled test done");
	endtask
	task automatic t_sync;
		wr(CT0, 8'h81);
		setV(1'h0);
		@(posedge clk);
		runTmr <= 1'h1;
		cyc(12);
		@(posedge clk);
		runTmr <= 1'h0;
		cyc(4);
		cmp("gateSource", 8'h00, 8'(gateSource));
		setV(1'h1);
		cyc(8);
		cmp("compareOut", 8'h01, 8'(compareOut));
		cmp("gateSource", 8'h00, 8'(gateSource));
		@(posedge clk);
		runTmr <= 1'h1;
		cyc(2);
		cmp("gateSource", 8'h00, 8'(gateSource));
		cyc(3);
		cmp("gateSource", 8'h01, 8'(gateSource));
		cmp("pinOut", 8'h01, 8'(pinOut));
		@(posedge clk);
		runTmr <= 1'h0;
		wr(CT0, 8'h80);
		setV(1'h0);
		cyc(3);
		cmp("gateSource", 8'h00, 8'(gateSource));
		cmp("pinOut", 8'h00, 8'(pinOut));
		// Unsynced pin path is not held back by the instruction-cycle latch
		setV(1'h1);
		#1;
		cmp("pinOut", 8'h01, 8'(pinOut));
		cmp("compareOut", 8'h00, 8'(compareOut));
		$display("sync test done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		t_reset();
		t_polarity();
		t_edges();
		t_collide();
		t_disabled();
		t_sync();
		wrap_up();
	end
	initial
	begin
		repeat (4000) @(posedge clk);
		errors++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule // cmpl_top_tb_top
`default_nettype wire
